// file: pkg/dss_pkg.sv
package dss_pkg;
    // register byte offsets
    localparam logic [11:0] DSS_OFF_CTRL = 12'h000;
    localparam logic [11:0] DSS_OFF_TRIP0 = 12'h004;
    localparam logic [11:0] DSS_OFF_HYST0 = 12'h008;
    localparam logic [11:0] DSS_OFF_TRIP1 = 12'h00c;
    localparam logic [11:0] DSS_OFF_HYST1 = 12'h010;
    localparam logic [11:0] DSS_OFF_COMMIT = 12'h014;
    localparam logic [11:0] DSS_OFF_STATUS = 12'h018;
    localparam logic [11:0] DSS_OFF_IRQ_STAT = 12'h01c;
    localparam logic [11:0] DSS_OFF_IRQ_MASK = 12'h020;
    localparam logic [11:0] DSS_OFF_ACT_TRIP0 = 12'h024;
    localparam logic [11:0] DSS_OFF_ACT_HYST0 = 12'h028;
    localparam logic [11:0] DSS_OFF_ACT_TRIP1 = 12'h02c;
    localparam logic [11:0] DSS_OFF_ACT_HYST1 = 12'h030;
    localparam logic [11:0] DSS_OFF_SPEED = 12'h034;
    // field positions
    localparam int DSS_CTRL_NC0_BIT = 0;
    localparam int DSS_CTRL_NC1_BIT = 1;
    localparam int DSS_COMMIT_BIT = 0;
    // irq layout: bit0/1 switch changed, bit2 commit done, bit3 commit refused
    localparam int DSS_IRQ_W = 4;
    localparam int DSS_IRQ_LOADED_BIT = 2;
    localparam int DSS_IRQ_REFUSED_BIT = 3;
    // ranges in rpm
    localparam int DSS_TRIP_MAX_RPM = 5000;
    localparam int DSS_HYST_MAX_RPM = 400;
    // reset values
    localparam logic [15:0] DSS_TRIP_RST = 16'h0000;
    localparam logic [15:0] DSS_HYST_RST = 16'h0000;
    localparam logic [1:0] DSS_NC_RST = 2'h0;
    localparam logic [3:0] DSS_MASK_RST = 4'h0;

    // one switch's settings
    typedef struct packed {
        logic [15:0] trip;
        logic [15:0] hyst;
        logic nc;
    } dss_cfg_t;

    // apb request bundle
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dss_apb_req_t;
endpackage

// file: hw/dss_trip.sv
`timescale 1ns/10ps
module dss_trip #(
    parameter int SPEED_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [SPEED_W-1:0] speed,
    input wire dss_pkg::dss_cfg_t cfg,
    output logic tripped
);
    import dss_pkg::*;

    initial begin
        if (SPEED_W < 16) begin
            $error("dss_trip: speed width below 16 cannot hold threshold");
        end
    end

    logic [SPEED_W:0] release_lvl; // trip minus hysteresis
    logic floor_release; // hysteresis swallows threshold
    logic rise;
    logic fall;

    // release level and zero-floor case
    always_comb begin
        floor_release = (cfg.hyst >= cfg.trip);
        release_lvl = {1'b0, SPEED_W'(cfg.trip)} - {1'b0, SPEED_W'(cfg.hyst)};
        rise = ({1'b0, speed} > {1'b0, SPEED_W'(cfg.trip)});
        if (floor_release) begin
            fall = (speed == '0);
        end else begin
            fall = ({1'b0, speed} < release_lvl);
        end
    end

    // state held in the band between levels, untripped after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tripped <= 1'b0;
        end else if (ce) begin
            if (!tripped && rise) begin
                tripped <= 1'b1;
            end else if (tripped && fall) begin
                tripped <= 1'b0;
            end
        end
    end
endmodule

// file: hw/dss_sync.sv
`timescale 1ns/10ps
module dss_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic s1; // metastability stage, read only by s2
    logic s2;
    logic s3;

    // three stages; change accepted when s2 and s3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule

// file: hw/dss_top.sv
`timescale 1ns/10ps
// Operation
// - two switches, trip zero to 5000 rpm
// - own hysteresis per switch, zero to 400
// - trips when speed rises above threshold
// - releases below threshold minus hysteresis
// - hysteresis at least threshold: release at zero
// - normally open: grounded only while tripped
// - normally closed: grounded only while untripped
// - indicator mirrors output state
// - staged settings act only after commit
// - active settings readable while running
module dss_top #(
    parameter int SPEED_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SPEED_W-1:0] speed,
    input wire logic engine_run_pin,
    output logic [1:0] gnd_oe_n,
    output logic [1:0] led,
    output logic irq
);
    import dss_pkg::*;

    initial begin
        if (SPEED_W < 16 || SPEED_W > 32) begin
            $error("dss_top: speed width must be 16..32");
        end
    end

    // the two switches share one speed input and differ only in their settings;
    // software writes a staged image and moves it into the active image in one
    // step, so a half-written set of thresholds never steers an output.
    // the active image keeps running while a load is refused, and a refusal
    // leaves its own sticky flag so the tool can tell a lost load from a slow one.
    // every output leaves a flip-flop; the cost is one cycle of latency from
    // a switch decision to its ground pin and indicator.
    // the run pin comes from outside the clock domain and is filtered before use.

    dss_apb_req_t req; // bundled bus request
    dss_cfg_t stage_cfg[2]; // settings being written by software
    dss_cfg_t act_cfg[2]; // settings steering the switches
    logic [1:0] tripped; // switch state
    logic engine_run; // filtered run indication
    logic [DSS_IRQ_W-1:0] irq_stat_reg;
    logic [DSS_IRQ_W-1:0] irq_mask_reg;
    logic [DSS_IRQ_W-1:0] irq_event;
    logic [1:0] tripped_d; // edge detect for trip events
    logic wr_acc; // write taken this edge
    logic rd_acc; // read taken this edge
    logic commit_req; // commit bit written
    logic [31:0] rd_mux;
    logic rd_err;
    logic wr_err;

    // decoding shared by read and write paths
    function automatic logic addr_known(input logic [11:0] a);
        case (a)
            DSS_OFF_CTRL, DSS_OFF_TRIP0, DSS_OFF_HYST0, DSS_OFF_TRIP1,
            DSS_OFF_HYST1, DSS_OFF_COMMIT, DSS_OFF_STATUS, DSS_OFF_IRQ_STAT,
            DSS_OFF_IRQ_MASK, DSS_OFF_ACT_TRIP0, DSS_OFF_ACT_HYST0,
            DSS_OFF_ACT_TRIP1, DSS_OFF_ACT_HYST1, DSS_OFF_SPEED: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    // value clipped to a documented maximum
    function automatic logic [15:0] clip(input logic [31:0] v, input int max);
        if (v > 32'(max)) begin
            return 16'(max);
        end
        return v[15:0];
    endfunction

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // one-wait slave: every access is answered in the cycle after its first access cycle
    always_comb begin
        wr_acc = req.sel && req.enable && req.write && !pready;
        rd_acc = req.sel && req.enable && !req.write && !pready;
        wr_err = !addr_known(req.addr);
        rd_err = !addr_known(req.addr);
        commit_req = wr_acc && !wr_err && (req.addr == DSS_OFF_COMMIT)
            && req.wdata[DSS_COMMIT_BIT];
    end

    // pready registered: one wait state, pulse in the cycle after penable rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (req.sel && req.enable && !pready) begin
                pready <= 1'b1;
                pslverr <= req.write ? wr_err : rd_err;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // staged settings, clipped to their legal ranges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                stage_cfg[i] <= '{trip: DSS_TRIP_RST, hyst: DSS_HYST_RST, nc: DSS_NC_RST[i]};
            end
        end else if (ce && wr_acc) begin
            unique case (req.addr)
                DSS_OFF_CTRL: begin
                    stage_cfg[0].nc <= req.wdata[DSS_CTRL_NC0_BIT];
                    stage_cfg[1].nc <= req.wdata[DSS_CTRL_NC1_BIT];
                end
                DSS_OFF_TRIP0: begin
                    stage_cfg[0].trip <= clip(req.wdata, DSS_TRIP_MAX_RPM);
                end
                DSS_OFF_HYST0: begin
                    stage_cfg[0].hyst <= clip(req.wdata, DSS_HYST_MAX_RPM);
                end
                DSS_OFF_TRIP1: begin
                    stage_cfg[1].trip <= clip(req.wdata, DSS_TRIP_MAX_RPM);
                end
                DSS_OFF_HYST1: begin
                    stage_cfg[1].hyst <= clip(req.wdata, DSS_HYST_MAX_RPM);
                end
                default: begin
                    // other offsets leave the staged image alone
                end
            endcase
        end
    end

    // whole image moves at once; refused while engine runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                act_cfg[i] <= '{trip: DSS_TRIP_RST, hyst: DSS_HYST_RST, nc: DSS_NC_RST[i]};
            end
        end else if (ce && commit_req && !engine_run) begin
            act_cfg[0] <= stage_cfg[0];
            act_cfg[1] <= stage_cfg[1];
        end
    end

    // run pin filter, guards against loading under way
    dss_sync u_run_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d(engine_run_pin),
        .q(engine_run)
    );

    // two independent comparators
    generate
        for (genvar g = 0; g < 2; g++) begin : g_sw
            dss_trip #(
                .SPEED_W(SPEED_W)
            ) u_trip (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .speed(speed),
                .cfg(act_cfg[g]),
                .tripped(tripped[g])
            );
        end
    endgenerate

    // open-drain ground outputs; enable low means grounded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gnd_oe_n <= 2'h3;
            led <= 2'h0;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (act_cfg[i].nc) begin
                    gnd_oe_n[i] <= tripped[i];
                    led[i] <= !tripped[i];
                end else begin
                    gnd_oe_n[i] <= !tripped[i];
                    led[i] <= tripped[i];
                end
            end
        end
    end

    // events: switch changes, load done, load refused
    always_comb begin
        irq_event[0] = tripped[0] ^ tripped_d[0];
        irq_event[1] = tripped[1] ^ tripped_d[1];
        irq_event[DSS_IRQ_LOADED_BIT] = commit_req && !engine_run;
        irq_event[DSS_IRQ_REFUSED_BIT] = commit_req && engine_run;
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tripped_d <= 2'h0;
            irq_stat_reg <= '0;
            irq_mask_reg <= DSS_MASK_RST;
            irq <= 1'b0;
        end else if (ce) begin
            tripped_d <= tripped;
            if (wr_acc && req.addr == DSS_OFF_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~req.wdata[DSS_IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
            if (wr_acc && req.addr == DSS_OFF_IRQ_MASK) begin
                irq_mask_reg <= req.wdata[DSS_IRQ_W-1:0];
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read mux; active image readable at any time
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (req.addr)
            DSS_OFF_CTRL: begin
                rd_mux = {30'h0, stage_cfg[1].nc, stage_cfg[0].nc};
            end
            DSS_OFF_TRIP0: begin
                rd_mux = {16'h0, stage_cfg[0].trip};
            end
            DSS_OFF_HYST0: begin
                rd_mux = {16'h0, stage_cfg[0].hyst};
            end
            DSS_OFF_TRIP1: begin
                rd_mux = {16'h0, stage_cfg[1].trip};
            end
            DSS_OFF_HYST1: begin
                rd_mux = {16'h0, stage_cfg[1].hyst};
            end
            DSS_OFF_STATUS: begin
                rd_mux = {27'h0, engine_run, act_cfg[1].nc, act_cfg[0].nc, tripped};
            end
            DSS_OFF_IRQ_STAT: begin
                rd_mux = {28'h0, irq_stat_reg};
            end
            DSS_OFF_IRQ_MASK: begin
                rd_mux = {28'h0, irq_mask_reg};
            end
            DSS_OFF_ACT_TRIP0: begin
                rd_mux = {16'h0, act_cfg[0].trip};
            end
            DSS_OFF_ACT_HYST0: begin
                rd_mux = {16'h0, act_cfg[0].hyst};
            end
            DSS_OFF_ACT_TRIP1: begin
                rd_mux = {16'h0, act_cfg[1].trip};
            end
            DSS_OFF_ACT_HYST1: begin
                rd_mux = {16'h0, act_cfg[1].hyst};
            end
            DSS_OFF_SPEED: begin
                rd_mux = 32'(speed);
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // read data registered alongside pready; no side effects on read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (rd_acc) begin
                prdata <= rd_err ? 32'h0000_0000 : rd_mux;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// file: verification/dss_sva.sv
`timescale 1ns/10ps
// port-level checks of the apb answer and switch outputs
module dss_sva #(
    parameter int SPEED_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [SPEED_W-1:0] speed,
    input wire logic engine_run_pin,
    input wire logic [1:0] gnd_oe_n,
    input wire logic [1:0] led,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // access phase still waiting for its answer
    sequence apb_wait;
        psel && penable && !pready && ce;
    endsequence
    // six cycles long enough for speed, state, outputs and irq to settle
    sequence quiet;
        ($stable(speed) && ce && !(psel && pwrite))[*6];
    endsequence
    a_led_mirror: assert property (led == ~gnd_oe_n)
        else $error("indicator differs from output");
    a_one_wait: assert property (apb_wait |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over two cycles");
    a_err_ready: assert property (pslverr |-> pready && $past(psel && penable))
        else $error("error without an answered access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_out_hold: assert property (quiet |-> $stable(gnd_oe_n))
        else $error("output moved with speed steady");
    a_irq_hold: assert property (quiet |-> $stable(irq))
        else $error("interrupt moved with speed steady");
endmodule

bind dss_top dss_sva #(.SPEED_W(SPEED_W)) sva_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed(speed),
    .engine_run_pin(engine_run_pin), .gnd_oe_n(gnd_oe_n), .led(led), .irq(irq));

// file: verification/dss_engine.sv
`timescale 1ns/10ps
// engine side: speed pickup, run contact, two pulled-up loads
module dss_engine (
    input wire logic pclk,
    input wire logic [15:0] target_rpm, // wanted reading
    input wire logic run_req, // engine turning
    input wire logic [1:0] gnd_oe_n, // device ground switches
    output logic [15:0] speed,
    output logic engine_run_pin,
    output logic [1:0] load_on
);
    // one fresh reading per clock, launched after the edge
    always @(posedge pclk) begin
        speed <= target_rpm;
    end
    // run contact, registered from run_req; the loads do not depend on it
    always @(posedge pclk) begin
        engine_run_pin <= run_req;
    end
    // lines pulled up, a load runs only while grounded
    assign load_on = ~gnd_oe_n;
    initial begin
        speed = 16'h0;
        engine_run_pin = 1'b0;
    end
endmodule

// file: verification/dual_speed_switch_bench.sv
`timescale 1ns/10ps
module dual_speed_switch_bench;
    import dss_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic err_seen;
    logic [15:0] speed;
    logic [15:0] target_rpm = 16'h0;
    logic run_req = 1'b0;
    logic engine_run_pin;
    logic [1:0] gnd_oe_n;
    logic [1:0] led;
    logic [1:0] load_on;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // reference model: active, staged, switch state, events
    int trip[2], hyst[2], nc[2], trp[2], st_t[2], st_h[2], st_nc[2];
    int ists = 0;
    int mask = 0;
    int cur = 0;

    // 50 ns period
    initial begin
        forever #25 pclk = ~pclk;
    end

    dss_top #(.SPEED_W(16)) dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed(speed), .engine_run_pin(engine_run_pin),
        .gnd_oe_n(gnd_oe_n), .led(led), .irq(irq));
    dss_engine eng_u (.pclk(pclk), .target_rpm(target_rpm), .run_req(run_req),
        .gnd_oe_n(gnd_oe_n), .speed(speed), .engine_run_pin(engine_run_pin), .load_on(load_on));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, far above the planned traffic
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end

    // one apb transfer, held until pready is sampled
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        err_seen = pslverr;
        if (n == 50) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] a, input int d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task rdchk(input logic [11:0] a, input int e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // one settled reading through the reference switches
    task model_speed(input int s);
        for (int i = 0; i < 2; i++) begin
            int old;
            old = trp[i];
            if (s > trip[i]) trp[i] = 1;
            else if (hyst[i] >= trip[i] ? s == 0 : s < trip[i] - hyst[i]) trp[i] = 0;
            if (trp[i] != old) ists |= 1 << i;
        end
    endtask

    // drive a reading, let it settle, compare ground, indicator, irq and load outputs
    task run_speed(input int s);
        logic [1:0] g;
        target_rpm <= 16'(s);
        cur = s;
        repeat (6) @(posedge pclk);
        model_speed(s);
        g = {1'(trp[1] ^ nc[1]), 1'(trp[0] ^ nc[0])};
        check({30'h0, gnd_oe_n}, {30'h0, ~g});
        check({30'h0, led}, {30'h0, g});
        check({31'h0, irq}, {31'h0, 1'(|(ists & mask))});
        check({30'h0, load_on}, {30'h0, g});
    endtask

    // staged values clip into range
    task stage(input int i, input int t, input int h, input int c);
        wr(i ? DSS_OFF_TRIP1 : DSS_OFF_TRIP0, t);
        wr(i ? DSS_OFF_HYST1 : DSS_OFF_HYST0, h);
        st_t[i] = t > DSS_TRIP_MAX_RPM ? DSS_TRIP_MAX_RPM : t;
        st_h[i] = h > DSS_HYST_MAX_RPM ? DSS_HYST_MAX_RPM : h;
        st_nc[i] = c;
        wr(DSS_OFF_CTRL, st_nc[1] * 2 + st_nc[0]);
    endtask

    // load staged settings; refused and flagged while running
    task commit;
        wr(DSS_OFF_COMMIT, 1);
        if (run_req) ists |= 8;
        else begin
            trip = st_t;
            hyst = st_h;
            nc = st_nc;
            ists |= 4;
        end
        run_speed(cur);
    endtask

    // run contact, long enough for the pin filter
    task engine(input logic on);
        run_req <= on;
        repeat (8) @(posedge pclk);
    endtask

    initial begin
        int r, s, t, h;
        r = $urandom(32'h5185);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({30'h0, gnd_oe_n}, 32'h3);
        check({30'h0, led}, 32'h0);
        rdchk(DSS_OFF_CTRL, 0);
        // bus is up and answering before any read-back of the active image
        rdchk(DSS_OFF_ACT_TRIP1, 0);
        rdchk(12'hffc, 0);
        check({31'h0, err_seen}, 32'h1);
        wr(DSS_OFF_IRQ_MASK, 1);
        mask = 1;
        stage(0, 6000, 500, 0);
        rdchk(DSS_OFF_TRIP0, 5000);
        rdchk(DSS_OFF_HYST0, 400);
        run_speed(100);
        run_speed(0);
        wr(DSS_OFF_IRQ_STAT, 32'hf);
        ists = 0;
        // load attempt while running must leave the active set alone
        engine(1);
        commit;
        rdchk(DSS_OFF_IRQ_STAT, ists);
        rdchk(DSS_OFF_ACT_TRIP0, 0);
        engine(0);
        // both polarities, boundaries, then random readings
        for (int k = 0; k < 2; k++) begin
            t = k ? 5000 : 400;
            h = k ? 0 : 50;
            stage(0, t, h, k);
            stage(1, k ? 0 : 350, 400, 1 - k);
            commit;
            engine(1);
            rdchk(DSS_OFF_ACT_TRIP0, t);
            rdchk(DSS_OFF_ACT_HYST1, 400);
            rdchk(DSS_OFF_STATUS, 16 + nc[1] * 8 + nc[0] * 4 + trp[1] * 2 + trp[0]);
            for (int n = 0; n < 30; n++) begin
                s = n == 0 ? t : n == 1 ? t + 1 : n == 2 ? t - h : n == 3 ? t - h - 1 :
                    n % 5 == 0 ? 0 : $urandom_range(t + 100);
                run_speed(s);
            end
            engine(0);
        end
        end_sim();
    end
endmodule
